// ===== rtl/flash_mode_cfg.svh
`ifndef FLASH_MODE_CFG_SVH
`define FLASH_MODE_CFG_SVH

// ******************************************
// instruction codes
// ******************************************
`define OP_WREN 8'h06
`define OP_VSR_WEN 8'h50
`define OP_WRSR 8'h01
`define OP_RDSR 8'h05
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_EN4B 8'hB7
`define OP_EX4B 8'hE9
`define OP_WREAR 8'hC5
`define OP_RDEAR 8'hC8
`define OP_QREAD 8'hEB

// ******************************************
// fields, counts and reset values
// ******************************************
`define MODE_CONT_NIB 4'hA
`define MODE_EXIT 8'h00
`define QE_POS 6
`define WEL_POS 1
`define DUMMY_BYTES 3'h2
`define ADDR3_BYTES 3'h3
`define ADDR4_BYTES 3'h4
`define SR1_RESET 8'h00
`define EXT_ADDR_RESET 8'h00
`define CONT_SUPPORT 1'b1

`endif

// ===== rtl/flash_mode_pkg.sv
package flash_mode_pkg;

  typedef enum logic [3:0] {
    ST_CMD = 4'h0,
    ST_ADDR = 4'h1,
    ST_MODE = 4'h2,
    ST_DUMMY = 4'h3,
    ST_QDATA = 4'h4,
    ST_WRSR = 4'h5,
    ST_WREAR = 4'h6,
    ST_RDOUT = 4'h7,
    ST_IGNORE = 4'h8
  } ctl_state_e;

endpackage

// ===== rtl/spi_lane_if.sv
`timescale 1ns/1ps
interface spi_lane_if;
  logic frame_start;
  logic cs_active;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic quad;
  logic tx_en;
  logic tx_load;
  logic [7:0] tx_byte;

  modport lane (output frame_start, cs_active, rx_valid, rx_byte,
                input quad, tx_en, tx_load, tx_byte);
  modport ctrl (input frame_start, cs_active, rx_valid, rx_byte,
                output quad, tx_en, tx_load, tx_byte);
endinterface

// ===== rtl/spi_lane.sv
`timescale 1ns/1ps
module spi_lane (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic spi_clk_pin,
  input wire logic cs_n_pin,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe,
  spi_lane_if.lane lane
);

  // ******************************************
  // pin synchronisers and edge detection
  // ******************************************
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic clk_s3_r;
  logic cs_n_s3_r;
  logic rise;
  logic fall;
  logic [3:0] bitcnt_r;
  logic [3:0] bitcnt_nxt;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic [7:0] tx_sh_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // clock bit resets to its idle low level, so no false edge follows reset
      s1_r <= 6'h3e;
      s2_r <= 6'h3e;
      clk_s3_r <= 1'b0;
      cs_n_s3_r <= 1'b1;
    end else begin
      s1_r <= {dq_in, cs_n_pin, spi_clk_pin};
      s2_r <= s1_r;
      clk_s3_r <= s2_r[0];
      cs_n_s3_r <= s2_r[1];
    end
  end

  assign rise = s2_r[0] & ~clk_s3_r & ~s2_r[1];
  assign fall = ~s2_r[0] & clk_s3_r & ~s2_r[1];
  assign bitcnt_nxt = bitcnt_r + (lane.quad ? 4'h4 : 4'h1);
  assign rx_sh_nxt = lane.quad ? {rx_sh_r[3:0], s2_r[5:2]} : {rx_sh_r[6:0], s2_r[2]};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lane.frame_start <= 1'b0;
      lane.cs_active <= 1'b0;
    end else begin
      lane.frame_start <= ~s2_r[1] & cs_n_s3_r;
      lane.cs_active <= ~s2_r[1];
    end
  end

  // ******************************************
  // receive shifter
  // ******************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bitcnt_r <= 4'h0;
      rx_sh_r <= 8'h00;
      lane.rx_valid <= 1'b0;
      lane.rx_byte <= 8'h00;
    end else begin
      lane.rx_valid <= 1'b0;
      if (s2_r[1]) begin
        bitcnt_r <= 4'h0;
      end else if (rise) begin
        rx_sh_r <= rx_sh_nxt;
        if (bitcnt_nxt[3]) begin
          bitcnt_r <= 4'h0;
          lane.rx_valid <= 1'b1;
          lane.rx_byte <= rx_sh_nxt;
        end else begin
          bitcnt_r <= bitcnt_nxt;
        end
      end
    end
  end

  // ******************************************
  // transmit shifter, changes on falling edge
  // ******************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh_r <= 8'h00;
      dq_out <= 4'h0;
      dq_oe <= 4'h0;
    end else begin
      if (lane.tx_load) begin
        tx_sh_r <= lane.tx_byte;
      end else if (fall && lane.tx_en) begin
        tx_sh_r <= lane.quad ? {tx_sh_r[3:0], 4'h0} : {tx_sh_r[6:0], 1'b0};
        dq_out <= lane.quad ? tx_sh_r[7:4] : {2'b00, tx_sh_r[7], 1'b0};
      end
      if (s2_r[1] || !lane.tx_en) begin
        dq_oe <= 4'h0;
      end else if (fall) begin
        dq_oe <= lane.quad ? 4'hf : 4'h2;
      end
    end
  end

endmodule // spi_lane

// ===== rtl/flash_mode_ctrl.sv
// Functional notes
// - continuous quad read lets later reads skip the instruction byte; support flag reads one.
// - a mode byte of 00h ends continuous mode once the current read completes.
// - any mode byte whose upper nibble is not A drops continuous read mode.
// - mode byte upper nibble A enters continuous mode; the quad enable bit must be set first.
// - 50h enables a write that activates the volatile status register 1 copy; 06h one that writes the non-volatile copy.
// - status register 1 holds volatile and non-volatile bits and 06h enables its write.
// - 66h then 99h restores the power-on state and leaves 4-byte addressing.
// - E9h returns to 3-byte addressing with no write enable needed.
// - an 8-bit volatile extended address register gives A31..A24 in 3-byte mode; C8h reads, C5h writes it.
// - hardware reset, software reset or power cycle all return to 3-byte addressing.
// - B7h enters 4-byte addressing with no write enable needed.
`include "flash_mode_cfg.svh"
`timescale 1ns/1ps
module flash_mode_ctrl
  import flash_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic spi_clk_pin,
  input wire logic cs_n_pin,
  input wire logic [3:0] quad_data_lines_in,
  output logic [3:0] quad_data_lines_out,
  output logic [3:0] quad_data_lines_oe,
  input wire logic [7:0] sr1_nv_init,
  input wire logic [7:0] array_data,
  output logic [31:0] array_addr,
  output logic array_rd,
  output logic [7:0] sr1_nv,
  output logic [7:0] sr1_vol,
  output logic sr1_vol_active,
  output logic write_enable_latch,
  output logic four_byte_mode,
  output logic [7:0] ext_addr,
  output logic cont_read_mode,
  output logic cont_read_support,
  output logic soft_reset_pulse
);

  function automatic logic is_cont_mode(input logic [7:0] m);
    return m[7:4] == `MODE_CONT_NIB;
  endfunction

  spi_lane_if lif();

  spi_lane u_lane (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .spi_clk_pin(spi_clk_pin),
    .cs_n_pin(cs_n_pin),
    .dq_in(quad_data_lines_in),
    .dq_out(quad_data_lines_out),
    .dq_oe(quad_data_lines_oe),
    .lane(lif.lane)
  );

  ctl_state_e state_r;
  logic [2:0] cnt_r;
  logic [7:0] cmd_r;
  logic [31:0] addr_r;
  logic vsr_wen_r;
  logic rst_en_r;
  logic loaded_r;
  logic [7:0] sr1_eff;
  logic quad_en;
  logic cmd_fire;
  logic mode_fire;
  logic wrsr_fire;
  logic ear_fire;
  logic soft_rst;
  logic [2:0] addr_bytes;

  // ******************************************
  // decode
  // ******************************************
  assign sr1_eff = sr1_vol_active ? sr1_vol : sr1_nv;
  assign quad_en = sr1_eff[`QE_POS];
  assign cmd_fire = lif.rx_valid && !lif.frame_start && state_r == ST_CMD;
  assign mode_fire = lif.rx_valid && !lif.frame_start && state_r == ST_MODE;
  assign wrsr_fire = lif.rx_valid && !lif.frame_start && state_r == ST_WRSR;
  assign ear_fire = lif.rx_valid && !lif.frame_start && state_r == ST_WREAR;
  assign soft_rst = cmd_fire && lif.rx_byte == `OP_RST && rst_en_r;
  assign addr_bytes = four_byte_mode ? `ADDR4_BYTES : `ADDR3_BYTES;
  assign lif.quad = state_r == ST_ADDR || state_r == ST_MODE || state_r == ST_DUMMY ||
                    state_r == ST_QDATA;
  assign lif.tx_en = state_r == ST_RDOUT || state_r == ST_QDATA;

  // ******************************************
  // command sequencer
  // ******************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_CMD;
      cnt_r <= 3'h0;
      cmd_r <= 8'h00;
      addr_r <= 32'h0000_0000;
    end else if (lif.frame_start) begin
      state_r <= cont_read_mode ? ST_ADDR : ST_CMD;
      cnt_r <= 3'h0;
    end else if (lif.rx_valid) begin
      case (state_r)
        ST_CMD: begin
          cmd_r <= lif.rx_byte;
          cnt_r <= 3'h0;
          case (lif.rx_byte)
            `OP_RDSR, `OP_RDEAR: state_r <= ST_RDOUT;
            `OP_WRSR: state_r <= (write_enable_latch || vsr_wen_r) ? ST_WRSR : ST_IGNORE;
            `OP_WREAR: state_r <= ST_WREAR;
            `OP_QREAD: state_r <= quad_en ? ST_ADDR : ST_IGNORE;
            default: state_r <= ST_IGNORE;
          endcase
        end
        ST_ADDR: begin
          addr_r <= {addr_r[23:0], lif.rx_byte};
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == addr_bytes - 3'h1) begin
            state_r <= ST_MODE;
          end
        end
        ST_MODE: begin
          state_r <= ST_DUMMY;
          cnt_r <= 3'h0;
        end
        ST_DUMMY: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == `DUMMY_BYTES - 3'h1) begin
            state_r <= ST_QDATA;
          end
        end
        ST_WRSR, ST_WREAR: state_r <= ST_IGNORE;
        default: state_r <= state_r;
      endcase
    end
  end

  // ******************************************
  // continuous read mode
  // ******************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cont_read_mode <= 1'b0;
      cont_read_support <= `CONT_SUPPORT;
    end else if (soft_rst) begin
      cont_read_mode <= 1'b0;
    end else if (mode_fire) begin
      // takes effect at the next frame, so 00h ends it after this read
      cont_read_mode <= cont_read_support && is_cont_mode(lif.rx_byte);
    end
  end

  // ******************************************
  // addressing mode and extended address
  // ******************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      four_byte_mode <= 1'b0;
      ext_addr <= `EXT_ADDR_RESET;
    end else if (soft_rst) begin
      four_byte_mode <= 1'b0;
      ext_addr <= `EXT_ADDR_RESET;
    end else if (cmd_fire && lif.rx_byte == `OP_EN4B) begin
      four_byte_mode <= 1'b1;
    end else if (cmd_fire && lif.rx_byte == `OP_EX4B) begin
      four_byte_mode <= 1'b0;
    end else if (ear_fire) begin
      ext_addr <= lif.rx_byte;
    end
  end

  // ******************************************
  // status register 1 and write enables
  // ******************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      loaded_r <= 1'b0;
      sr1_nv <= `SR1_RESET;
      sr1_vol <= `SR1_RESET;
      sr1_vol_active <= 1'b0;
      write_enable_latch <= 1'b0;
      vsr_wen_r <= 1'b0;
      rst_en_r <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
      soft_reset_pulse <= soft_rst;
      if (!loaded_r) begin
        sr1_nv <= sr1_nv_init;
      end
      if (cmd_fire) begin
        rst_en_r <= lif.rx_byte == `OP_RST_EN;
      end
      if (soft_rst) begin
        sr1_vol_active <= 1'b0;
        write_enable_latch <= 1'b0;
        vsr_wen_r <= 1'b0;
      end else if (cmd_fire && lif.rx_byte == `OP_WREN) begin
        write_enable_latch <= 1'b1;
        vsr_wen_r <= 1'b0;
      end else if (cmd_fire && lif.rx_byte == `OP_VSR_WEN) begin
        vsr_wen_r <= 1'b1;
      end else if (wrsr_fire) begin
        if (vsr_wen_r) begin
          sr1_vol <= lif.rx_byte;
          sr1_vol_active <= 1'b1;
        end else begin
          sr1_nv <= lif.rx_byte;
        end
        write_enable_latch <= 1'b0;
        vsr_wen_r <= 1'b0;
      end
    end
  end

  // ******************************************
  // read data path
  // ******************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lif.tx_load <= 1'b0;
      lif.tx_byte <= 8'h00;
      array_addr <= 32'h0000_0000;
      array_rd <= 1'b0;
    end else begin
      lif.tx_load <= 1'b0;
      array_rd <= 1'b0;
      if (lif.rx_valid && !lif.frame_start) begin
        if (mode_fire) begin
          // upper byte from extended address in 3-byte mode
          array_addr <= four_byte_mode ? addr_r : {ext_addr, addr_r[23:0]};
        end
        if ((state_r == ST_CMD && (lif.rx_byte == `OP_RDSR || lif.rx_byte == `OP_RDEAR))
            || state_r == ST_RDOUT) begin
          lif.tx_load <= 1'b1;
          if ((state_r == ST_CMD ? lif.rx_byte : cmd_r) == `OP_RDEAR) begin
            lif.tx_byte <= ext_addr;
          end else begin
            lif.tx_byte <= {sr1_eff[7:2], write_enable_latch, 1'b0};
          end
        end
        if (state_r == ST_QDATA ||
            (state_r == ST_DUMMY && cnt_r == `DUMMY_BYTES - 3'h1)) begin
          lif.tx_load <= 1'b1;
          lif.tx_byte <= array_data;
          array_rd <= 1'b1;
          array_addr <= array_addr + 32'h0000_0001;
        end
      end
    end
  end

  // ******************************************
  // checks
  // ******************************************
  property p_en4b;
    @(posedge sys_clk) disable iff (!nrst)
      cmd_fire && lif.rx_byte == `OP_EN4B |=> four_byte_mode;
  endproperty
  a_en4b: assert property (p_en4b) else $error("B7h did not enter 4-byte mode");

  property p_ex4b;
    @(posedge sys_clk) disable iff (!nrst)
      cmd_fire && lif.rx_byte == `OP_EX4B |=> !four_byte_mode;
  endproperty
  a_ex4b: assert property (p_ex4b) else $error("E9h did not leave 4-byte mode");

  property p_wrear;
    @(posedge sys_clk) disable iff (!nrst)
      ear_fire |=> ext_addr == $past(lif.rx_byte);
  endproperty
  a_wrear: assert property (p_wrear) else $error("extended address not written");

  property p_cont_in;
    @(posedge sys_clk) disable iff (!nrst)
      mode_fire && is_cont_mode(lif.rx_byte) |=> cont_read_mode;
  endproperty
  a_cont_in: assert property (p_cont_in) else $error("Axh did not enter continuous");

  property p_cont_out;
    @(posedge sys_clk) disable iff (!nrst)
      mode_fire && !is_cont_mode(lif.rx_byte) |=> !cont_read_mode;
  endproperty
  a_cont_out: assert property (p_cont_out) else $error("non Axh kept continuous");

  property p_cont_zero;
    @(posedge sys_clk) disable iff (!nrst)
      mode_fire && lif.rx_byte == `MODE_EXIT |=> !cont_read_mode [*2];
  endproperty
  a_cont_zero: assert property (p_cont_zero) else $error("00h kept continuous");

  property p_cont_skip;
    @(posedge sys_clk) disable iff (!nrst)
      lif.frame_start && cont_read_mode |=> state_r == ST_ADDR && lif.quad;
  endproperty
  a_cont_skip: assert property (p_cont_skip) else $error("instruction not skipped");

  property p_qe;
    @(posedge sys_clk) disable iff (!nrst)
      cmd_fire && lif.rx_byte == `OP_QREAD && !quad_en |=> state_r == ST_IGNORE;
  endproperty
  a_qe: assert property (p_qe) else $error("quad read without quad enable");

  property p_soft_rst;
    @(posedge sys_clk) disable iff (!nrst)
      soft_rst |=> soft_reset_pulse && !four_byte_mode && !cont_read_mode && !sr1_vol_active &&
               ext_addr == `EXT_ADDR_RESET ##1 !soft_reset_pulse;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset incomplete");

  property p_vsr;
    @(posedge sys_clk) disable iff (!nrst)
      wrsr_fire && vsr_wen_r |=> sr1_vol_active && sr1_vol == $past(lif.rx_byte);
  endproperty
  a_vsr: assert property (p_vsr) else $error("volatile status not activated");

  property p_nv;
    @(posedge sys_clk) disable iff (!nrst)
      wrsr_fire && !vsr_wen_r |=> sr1_nv == $past(lif.rx_byte) && !write_enable_latch;
  endproperty
  a_nv: assert property (p_nv) else $error("non-volatile status not written");

endmodule // flash_mode_ctrl

// ===== bench/host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model (
  input wire logic sys_clk,
  input wire logic [3:0] dq_line,
  output logic spi_clk,
  output logic cs_n,
  output logic [3:0] dq_drv
);
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    dq_drv = 4'h0;
  end
  // ******************************************
  // one serial clock, 5 low and 3 high
  // ******************************************
  // released lines show the inverse of their last value
  task automatic tick(input logic [3:0] val, input logic [3:0] en, output logic [3:0] seen);
    @(posedge sys_clk);
    spi_clk <= 1'b0;
    dq_drv <= (val & en) | (~dq_drv & ~en);
    repeat (4) @(posedge sys_clk);
    #1 seen = dq_line;
    @(posedge sys_clk);
    spi_clk <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic byte1(input logic [7:0] b, output logic [7:0] r);
    logic [3:0] s;
    for (int i = 7; i >= 0; i--) begin
      tick({3'b000, b[i]}, 4'h1, s);
      r[i] = s[1];
    end
  endtask
  task automatic frame_on();
    @(posedge sys_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic frame_off();
    @(posedge sys_clk);
    spi_clk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  // all ones on four lines for eight clocks
  task automatic ffh_exit();
    logic [3:0] s;
    frame_on();
    repeat (8) tick(4'hF, 4'hF, s);
    frame_off();
  endtask
endmodule // host_spi_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  import flash_mode_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic has_d;
    logic [7:0] d;
    logic f4;
    logic [7:0] ext;
    logic [7:0] nv;
    logic va;
    logic wel;
  } row_s;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sr1_nv_init = 8'h00;
  logic spi_clk, cs_n, array_rd, sr1_vol_active, write_enable_latch, four_byte_mode;
  logic cont_read_mode, cont_read_support, soft_reset_pulse, got;
  logic [3:0] dq_drv, dq_out, dq_oe, dq_line;
  logic [7:0] array_data, sr1_nv, sr1_vol, ext_addr, q;
  logic [31:0] array_addr;
  int n_fail = 0;
  int checks = 0;
  int rd_n = 0;
  int rd0;
  row_s rows [10];
  always #10 sys_clk = ~sys_clk;
  assign dq_line = (dq_oe & dq_out) | (~dq_oe & dq_drv);
  // array content follows the address
  assign array_data = array_addr[7:0] ^ 8'hC3;
  always @(posedge sys_clk) begin
    if (array_rd === 1'b1) begin
      rd_n <= rd_n + 1;
    end
  end
  host_spi_model h (.sys_clk(sys_clk), .dq_line(dq_line), .spi_clk(spi_clk), .cs_n(cs_n),
    .dq_drv(dq_drv));
  flash_mode_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .spi_clk_pin(spi_clk), .cs_n_pin(cs_n),
    .quad_data_lines_in(dq_line), .quad_data_lines_out(dq_out), .quad_data_lines_oe(dq_oe),
    .sr1_nv_init(sr1_nv_init), .array_data(array_data), .array_addr(array_addr),
    .array_rd(array_rd), .sr1_nv(sr1_nv), .sr1_vol(sr1_vol), .sr1_vol_active(sr1_vol_active),
    .write_enable_latch(write_enable_latch), .four_byte_mode(four_byte_mode),
    .ext_addr(ext_addr), .cont_read_mode(cont_read_mode),
    .cont_read_support(cont_read_support), .soft_reset_pulse(soft_reset_pulse));
  // ******************************************
  // helpers
  // ******************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic has_d, input logic [7:0] d);
    logic [7:0] r;
    h.frame_on();
    h.byte1(op, r);
    if (has_d) h.byte1(d, r);
    h.frame_off();
  endtask
  task automatic qread(input logic first, input logic w, input logic [7:0] mode,
    output logic [7:0] o);
    logic [7:0] r;
    logic [3:0] s;
    logic [31:0] a;
    a = 32'h5612_3400;
    h.frame_on();
    if (first) h.byte1(8'hEB, r);
    for (int i = w ? 7 : 5; i >= 0; i--) h.tick(a[i*4+:4], 4'hF, s);
    h.tick(mode[7:4], 4'hF, s);
    h.tick(mode[3:0], 4'hF, s);
    repeat (4) h.tick(4'h0, 4'h0, s);
    h.tick(4'h0, 4'h0, s);
    o[7:4] = s;
    h.tick(4'h0, 4'h0, s);
    o[3:0] = s;
    h.frame_off();
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end
  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    rows[0] = {8'hB7, 1'b0, 8'h00, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0};
    rows[1] = {8'hE9, 1'b0, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0};
    rows[2] = {8'hB7, 1'b0, 8'h00, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0};
    rows[3] = {8'hC5, 1'b1, 8'h5A, 1'b1, 8'h5A, 8'h00, 1'b0, 1'b0};
    rows[4] = {8'hC5, 1'b1, 8'h00, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0};
    rows[5] = {8'hC5, 1'b1, 8'h3C, 1'b1, 8'h3C, 8'h00, 1'b0, 1'b0};
    rows[6] = {8'h06, 1'b0, 8'h00, 1'b1, 8'h3C, 8'h00, 1'b0, 1'b1};
    rows[7] = {8'h01, 1'b1, 8'h40, 1'b1, 8'h3C, 8'h40, 1'b0, 1'b0};
    rows[8] = {8'h01, 1'b1, 8'h04, 1'b1, 8'h3C, 8'h40, 1'b0, 1'b0};
    rows[9] = {8'h50, 1'b0, 8'h00, 1'b1, 8'h3C, 8'h40, 1'b0, 1'b0};
    repeat (9) @(posedge sys_clk);
    check("support", cont_read_support, 1'b1);
    check("four byte in reset", four_byte_mode, 1'b0);
    check("cont in reset", cont_read_mode, 1'b0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    $display("test reset done");
    qread(1'b1, 1'b0, 8'hA5, q);
    check("cont without quad enable", cont_read_mode, 1'b0);
    $display("test refused quad read done");
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].has_d, rows[i].d);
      check("four byte", four_byte_mode, rows[i].f4);
      check("ext addr", ext_addr, rows[i].ext);
      check("sr1 nv", sr1_nv, rows[i].nv);
      check("vol active", sr1_vol_active, rows[i].va);
      if (rows[i].op != 8'h50) check("wel", write_enable_latch, rows[i].wel);
    end
    $display("test table done");
    cmd(8'h01, 1'b1, 8'h44);
    check("vol active", sr1_vol_active, 1'b1);
    check("sr1 vol", sr1_vol, 8'h44);
    check("sr1 nv kept", sr1_nv, 8'h40);
    h.frame_on();
    h.byte1(8'h05, q);
    h.byte1(8'h00, q);
    h.frame_off();
    check("status read", q, 8'h44);
    h.frame_on();
    h.byte1(8'hC8, q);
    h.byte1(8'h00, q);
    h.frame_off();
    check("ext read", q, 8'h3C);
    $display("test volatile status done");
    rd0 = rd_n;
    qread(1'b1, 1'b1, 8'h00, q);
    check("wide data", q, 8'hC3);
    check("wide addr", array_addr[31:8], 24'h56_1234);
    check("array reads", rd_n - rd0, 2);
    check("cont after wide", cont_read_mode, 1'b0);
    $display("test wide read done");
    cmd(8'h99, 1'b0, 8'h00);
    check("lone reset ignored", four_byte_mode, 1'b1);
    cmd(8'h66, 1'b0, 8'h00);
    got = 1'b0;
    fork
      cmd(8'h99, 1'b0, 8'h00);
      for (int i = 0; i < 200 && !got; i++) begin
        @(posedge sys_clk);
        #1 got = (soft_reset_pulse === 1'b1);
      end
    join
    check("reset pulse", got, 1'b1);
    check("four byte after reset", four_byte_mode, 1'b0);
    check("ext after reset", ext_addr, 8'h00);
    check("vol after reset", sr1_vol_active, 1'b0);
    $display("test soft reset done");
    for (int k = 0; k < 2; k++) begin
      qread(1'b1, 1'b0, 8'hA5, q);
      check("first data", q, 8'hC3);
      check("addr", array_addr[31:8], 24'h00_1234);
      check("cont entered", cont_read_mode, 1'b1);
      qread(1'b0, 1'b0, 8'hA0, q);
      check("data no opcode", q, 8'hC3);
      check("cont kept", cont_read_mode, 1'b1);
      qread(1'b0, 1'b0, (k == 0) ? 8'h00 : 8'h33, q);
      check("last data", q, 8'hC3);
      check("cont left", cont_read_mode, 1'b0);
    end
    qread(1'b1, 1'b0, 8'hA5, q);
    h.ffh_exit();
    check("cont after ones", cont_read_mode, 1'b0);
    $display("test continuous read done");
    cmd(8'hB7, 1'b0, 8'h00);
    sr1_nv_init <= 8'h48;
    nrst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("four byte after hard reset", four_byte_mode, 1'b0);
    check("nv capture", sr1_nv, 8'h48);
    $display("test second reset done");
    close_out();
  end
endmodule // tb
